// *** rtl/gpio_output_driver_ctrl_regs.sv ***
// Register bank for general-purpose pin functions and clock output pair driver control.
// Functional notes
// - Direction bit 0 makes a pin input, 1 output; all reset to input.
// - Pin 0 input code 000 is general input, 001 (reset) is enable select 0.
// - Pin 1 input code 000 is general input, 001 (reset) is enable select 1.
// - Pin 2 input code 000 is general input, 001 (reset) is manual reference select.
// - Pin 3 input code 000 is general input; every other code is reserved.
// - Pins used as general inputs are readable at address 0x0219.
// - Pin 0 output code 000 drives stored value, 001 the holdover flag.
// - Pin 1 output code 000 drives stored value, 001 reference 1 signal loss.
// - Pin 2 output code 000 drives stored value, 001 reference 0 signal loss.
// - Pin 3 output code 000 drives stored value, 001 the loss-of-lock flag.
// - Stored output values, reset zero, drive pins in general output function.
// - Clock pair is high impedance unless its enable bit is set and select allows.
// - Style field: 000 off, 001 LVPECL reset, 010 LVDS, 011 LVCMOS, 100 HCSL.
// - In LVCMOS, phase bit 0 gives opposite phase pins, 1 same phase.
// - Function code bits 2, 1, 0 come from three registers, pin n at bit n.
`timescale 1ns/1ps
`include "gpio_ctrl_defs.svh"
module gpio_output_driver_ctrl_regs #(
	parameter int PIN_COUNT  = 4,
	parameter int PAIR_COUNT = 4
) (
	// Clock and reset
	input  wire logic         MCLK,
	input  wire logic         RESETN,
	// Register port from the serial host port
	input  wire logic [15:0]  REG_ADDR,
	input  wire logic         REG_WR,
	input  wire logic [7:0]   REG_WDATA,
	input  wire logic         REG_RD,
	output      logic [7:0]   REG_RDATA,
	// General-purpose pins
	input  wire logic [3:0]   GPIO_IN,
	output      logic [3:0]   GPIO_OUT,
	output      logic [3:0]   GPIO_OE,
	// PLL status and manual reference select
	input  wire logic         HOLDOVER_FLAG,
	input  wire logic         LOS_REF0,
	input  wire logic         LOS_REF1,
	input  wire logic         LOSS_OF_LOCK,
	output      logic         MANUAL_REF_SELECT,
	// Clock output pair driver control
	output      logic [3:0]   CLKOUT_DRIVE,
	output      logic [11:0]  CLKOUT_STYLE,
	output      logic [3:0]   CLKOUT_Q_INVERT,
	output      logic [3:0]   CLKOUT_NQ_INVERT
);
	import gpio_ctrl_pkg::*;

	if (PIN_COUNT != 4 || PAIR_COUNT != 4) begin : g_check
		$error("bank serves exactly four pins and four pairs");
	end

	logic [3:0] pin_direction;
	logic [3:0] in_fn_bit2;
	logic [3:0] in_fn_bit1;
	logic [3:0] in_fn_bit0;
	logic [3:0] out_fn_bit2;
	logic [3:0] out_fn_bit1;
	logic [3:0] out_fn_bit0;
	logic [3:0] general_output_values;
	logic [3:0] clock_output_enable_bits;
	logic [3:0] clock_output_polarity_bits;
	logic [7:0] driver_style_32;
	logic [7:0] driver_style_10;
	logic [3:0] next_pin_direction;
	logic [3:0] next_in_fn_bit2;
	logic [3:0] next_in_fn_bit1;
	logic [3:0] next_in_fn_bit0;
	logic [3:0] next_out_fn_bit2;
	logic [3:0] next_out_fn_bit1;
	logic [3:0] next_out_fn_bit0;
	logic [3:0] next_general_output_values;
	logic [3:0] next_clock_output_enable_bits;
	logic [3:0] next_clock_output_polarity_bits;
	logic [7:0] next_driver_style_32;
	logic [7:0] next_driver_style_10;
	logic [7:0] next_rdata;
	logic [3:0] sync_stage1;
	logic [3:0] pin_level;
	logic [3:0] general_input_values;
	logic [3:0] alt_level;
	logic [3:0] status_by_pin;
	logic [1:0] output_enable_select;
	logic [11:0] style_fields;
	logic [3:0] phase_fields;
	localparam logic [3:0] alt_idle = `ALT_IDLE_LEVEL;
	// Register writes and reads.
	always_comb begin
		next_pin_direction              = pin_direction;
		next_in_fn_bit2                 = in_fn_bit2;
		next_in_fn_bit1                 = in_fn_bit1;
		next_in_fn_bit0                 = in_fn_bit0;
		next_out_fn_bit2                = out_fn_bit2;
		next_out_fn_bit1                = out_fn_bit1;
		next_out_fn_bit0                = out_fn_bit0;
		next_general_output_values      = general_output_values;
		next_clock_output_enable_bits   = clock_output_enable_bits;
		next_clock_output_polarity_bits = clock_output_polarity_bits;
		next_driver_style_32            = driver_style_32;
		next_driver_style_10            = driver_style_10;
		next_rdata                      = REG_RDATA;
		if (REG_WR) begin
			case (REG_ADDR)
				`ADDR_PIN_DIRECTION:        next_pin_direction = REG_WDATA[3:0];
				`ADDR_PIN_IN_FN_BIT2:       next_in_fn_bit2 = REG_WDATA[3:0];
				`ADDR_PIN_IN_FN_BIT1:       next_in_fn_bit1 = REG_WDATA[3:0];
				`ADDR_PIN_IN_FN_BIT0:       next_in_fn_bit0 = REG_WDATA[3:0];
				`ADDR_PIN_OUT_FN_BIT2:      next_out_fn_bit2 = REG_WDATA[3:0];
				`ADDR_PIN_OUT_FN_BIT1:      next_out_fn_bit1 = REG_WDATA[3:0];
				`ADDR_PIN_OUT_FN_BIT0:      next_out_fn_bit0 = REG_WDATA[3:0];
				`ADDR_PIN_OUTPUT_VALUES:    next_general_output_values = REG_WDATA[3:0];
				`ADDR_CLOCK_OUTPUT_ENABLES: next_clock_output_enable_bits = REG_WDATA[3:0];
				`ADDR_CLOCK_OUTPUT_POL:     next_clock_output_polarity_bits = REG_WDATA[3:0];
				`ADDR_DRIVER_STYLE_32:      next_driver_style_32 = REG_WDATA;
				`ADDR_DRIVER_STYLE_10:      next_driver_style_10 = REG_WDATA;
				default:                    next_rdata = REG_RDATA;
			endcase
		end
		// Reserved bits are not stored, so they read back as zero.
		if (REG_RD) begin
			case (REG_ADDR)
				`ADDR_PIN_DIRECTION:        next_rdata = {`READ_PAD, pin_direction};
				`ADDR_PIN_IN_FN_BIT2:       next_rdata = {`READ_PAD, in_fn_bit2};
				`ADDR_PIN_IN_FN_BIT1:       next_rdata = {`READ_PAD, in_fn_bit1};
				`ADDR_PIN_IN_FN_BIT0:       next_rdata = {`READ_PAD, in_fn_bit0};
				`ADDR_PIN_OUT_FN_BIT2:      next_rdata = {`READ_PAD, out_fn_bit2};
				`ADDR_PIN_OUT_FN_BIT1:      next_rdata = {`READ_PAD, out_fn_bit1};
				`ADDR_PIN_OUT_FN_BIT0:      next_rdata = {`READ_PAD, out_fn_bit0};
				`ADDR_PIN_OUTPUT_VALUES:    next_rdata = {`READ_PAD, general_output_values};
				`ADDR_CLOCK_OUTPUT_ENABLES: next_rdata = {`READ_PAD, clock_output_enable_bits};
				`ADDR_CLOCK_OUTPUT_POL:     next_rdata = {`READ_PAD, clock_output_polarity_bits};
				`ADDR_DRIVER_STYLE_32:      next_rdata = driver_style_32;
				`ADDR_DRIVER_STYLE_10:      next_rdata = driver_style_10;
				`ADDR_GENERAL_INPUTS:       next_rdata = {`READ_PAD, general_input_values};
				default:                    next_rdata = `READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			pin_direction              <= `RST_FOUR_BITS;
			in_fn_bit2                 <= `RST_FOUR_BITS;
			in_fn_bit1                 <= `RST_FOUR_BITS;
			in_fn_bit0                 <= `RST_IN_FN_BIT0;
			out_fn_bit2                <= `RST_FOUR_BITS;
			out_fn_bit1                <= `RST_FOUR_BITS;
			out_fn_bit0                <= `RST_FOUR_BITS;
			general_output_values      <= `RST_FOUR_BITS;
			clock_output_enable_bits   <= `RST_FOUR_BITS;
			clock_output_polarity_bits <= `RST_FOUR_BITS;
			driver_style_32            <= `RST_DRIVER_STYLE;
			driver_style_10            <= `RST_DRIVER_STYLE;
			REG_RDATA                  <= `RST_READ_DATA;
		end else begin
			pin_direction              <= next_pin_direction;
			in_fn_bit2                 <= next_in_fn_bit2;
			in_fn_bit1                 <= next_in_fn_bit1;
			in_fn_bit0                 <= next_in_fn_bit0;
			out_fn_bit2                <= next_out_fn_bit2;
			out_fn_bit1                <= next_out_fn_bit1;
			out_fn_bit0                <= next_out_fn_bit0;
			general_output_values      <= next_general_output_values;
			clock_output_enable_bits   <= next_clock_output_enable_bits;
			clock_output_polarity_bits <= next_clock_output_polarity_bits;
			driver_style_32            <= next_driver_style_32;
			driver_style_10            <= next_driver_style_10;
			REG_RDATA                  <= next_rdata;
		end
	end

	// Pins come from the board, so they pass two flops before any decode looks at them.
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			sync_stage1 <= `RST_SYNC;
			pin_level   <= `RST_SYNC;
		end else begin
			sync_stage1 <= GPIO_IN;
			pin_level   <= sync_stage1;
		end
	end

	assign status_by_pin = {LOSS_OF_LOCK, LOS_REF0, LOS_REF1, HOLDOVER_FLAG};

	for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
		logic [2:0] in_fn;
		logic [2:0] out_fn;
		logic       next_out;
		logic       next_oe;
		logic       next_gpi;
		logic       next_alt;

		assign in_fn  = {in_fn_bit2[n], in_fn_bit1[n], in_fn_bit0[n]};
		assign out_fn = {out_fn_bit2[n], out_fn_bit1[n], out_fn_bit0[n]};

		always_comb begin
			next_oe  = pin_direction[n];
			next_out = 1'b0;
			next_gpi = 1'b0;
			next_alt = alt_idle[n];
			if (pin_direction[n]) begin
				case (out_fn)
					OUT_FN_GENERAL: next_out = general_output_values[n];
					OUT_FN_STATUS:  next_out = status_by_pin[n];
					default:        next_out = 1'b0;
				endcase
			end else begin
				case (in_fn)
					IN_FN_GENERAL:   next_gpi = pin_level[n];
					// Pin 3 has no alternate input, so its code 001 stays inert.
					IN_FN_ALTERNATE: next_alt = (n != 3) ? pin_level[n] : alt_idle[n];
					default:         next_gpi = 1'b0;
				endcase
			end
		end

		always_ff @(posedge MCLK or negedge RESETN) begin
			if (!RESETN) begin
				GPIO_OUT[n]             <= 1'b0;
				GPIO_OE[n]              <= 1'b0;
				general_input_values[n] <= 1'b0;
				alt_level[n]            <= alt_idle[n];
			end else begin
				GPIO_OUT[n]             <= next_out;
				GPIO_OE[n]              <= next_oe;
				general_input_values[n] <= next_gpi;
				alt_level[n]            <= next_alt;
			end
		end
	end

	assign output_enable_select = alt_level[1:0];
	assign MANUAL_REF_SELECT    = alt_level[2];

	assign style_fields = {driver_style_32[`STYLE_HI_LSB +: `STYLE_WIDTH], driver_style_32[`STYLE_LO_LSB +: `STYLE_WIDTH],
	                       driver_style_10[`STYLE_HI_LSB +: `STYLE_WIDTH], driver_style_10[`STYLE_LO_LSB +: `STYLE_WIDTH]};
	assign phase_fields = {driver_style_32[`SE_HI_BIT], driver_style_32[`SE_LO_BIT],
	                       driver_style_10[`SE_HI_BIT], driver_style_10[`SE_LO_BIT]};

	for (genvar m = 0; m < PAIR_COUNT; m++) begin : g_pair
		driver_style_t style_out;

		// Select bit 0 gates pairs 0 and 1, select bit 1 gates pairs 2 and 3.
		clock_pair_ctrl u_pair (
			.clk        (MCLK),
			.resetn     (RESETN),
			.enable     (clock_output_enable_bits[m]),
			.gate       (output_enable_select[m / 2]),
			.polarity   (clock_output_polarity_bits[m]),
			.style      (driver_style_t'(style_fields[m * 3 +: 3])),
			.same_phase (phase_fields[m]),
			.drive      (CLKOUT_DRIVE[m]),
			.style_out  (style_out),
			.q_invert   (CLKOUT_Q_INVERT[m]),
			.nq_invert  (CLKOUT_NQ_INVERT[m])
		);
		assign CLKOUT_STYLE[m * 3 +: 3] = style_out;
	end

	property p_direction;
		@(posedge MCLK) disable iff (!RESETN) 1'b1 |=> GPIO_OE == $past(pin_direction);
	endproperty
	a_direction: assert property (p_direction) else $error("drive enable differs from direction");

	property p_gpi_pin0;
		@(posedge MCLK) disable iff (!RESETN)
			!pin_direction[0] && g_pin[0].in_fn == 3'h0 |=> general_input_values[0] == $past(pin_level[0]);
	endproperty
	a_gpi_pin0: assert property (p_gpi_pin0) else $error("pin 0 input not reflected");

	property p_manual_reference_select;
		@(posedge MCLK) disable iff (!RESETN)
			!pin_direction[2] && g_pin[2].in_fn == 3'h1 |=> MANUAL_REF_SELECT == $past(pin_level[2]);
	endproperty
	a_manual_reference_select: assert property (p_manual_reference_select) else $error("reference select not taken from pin 2");

	property p_pin3_alt_inert;
		@(posedge MCLK) disable iff (!RESETN) 1'b1 |=> alt_level[3] == 1'b0;
	endproperty
	a_pin3_alt_inert: assert property (p_pin3_alt_inert) else $error("pin 3 reserved code acted");

	property p_gpi_read;
		@(posedge MCLK) disable iff (!RESETN)
			REG_RD && REG_ADDR == `ADDR_GENERAL_INPUTS |=> REG_RDATA == {4'h0, $past(general_input_values)};
	endproperty
	a_gpi_read: assert property (p_gpi_read) else $error("general inputs not read back");

	property p_holdover_out;
		@(posedge MCLK) disable iff (!RESETN)
			pin_direction[0] && g_pin[0].out_fn == 3'h1 |=> GPIO_OUT[0] == $past(HOLDOVER_FLAG);
	endproperty
	a_holdover_out: assert property (p_holdover_out) else $error("holdover flag not on pin 0");

	property p_los1_out;
		@(posedge MCLK) disable iff (!RESETN)
			pin_direction[1] && g_pin[1].out_fn == 3'h1 |=> GPIO_OUT[1] == $past(LOS_REF1);
	endproperty
	a_los1_out: assert property (p_los1_out) else $error("reference 1 loss not on pin 1");

	property p_los0_out;
		@(posedge MCLK) disable iff (!RESETN)
			pin_direction[2] && g_pin[2].out_fn == 3'h1 |=> GPIO_OUT[2] == $past(LOS_REF0);
	endproperty
	a_los0_out: assert property (p_los0_out) else $error("reference 0 loss not on pin 2");

	property p_lol_out;
		@(posedge MCLK) disable iff (!RESETN)
			pin_direction[3] && g_pin[3].out_fn == 3'h1 |=> GPIO_OUT[3] == $past(LOSS_OF_LOCK);
	endproperty
	a_lol_out: assert property (p_lol_out) else $error("loss of lock not on pin 3");

	property p_gpo_write;
		@(posedge MCLK) disable iff (!RESETN)
			REG_WR && REG_ADDR == `ADDR_PIN_OUTPUT_VALUES && pin_direction[0] && g_pin[0].out_fn == 3'h0 ##1
			g_pin[0].out_fn == 3'h0 && pin_direction[0] |=> GPIO_OUT[0] == $past(REG_WDATA[0], 2);
	endproperty
	a_gpo_write: assert property (p_gpo_write) else $error("stored output not driven");

	property p_fn_assembly;
		@(posedge MCLK) disable iff (!RESETN)
			REG_WR && REG_ADDR == `ADDR_PIN_OUT_FN_BIT2 |=> g_pin[1].out_fn[2] == $past(REG_WDATA[1]);
	endproperty
	a_fn_assembly: assert property (p_fn_assembly) else $error("code bit 2 misplaced");

	property p_input_released;
		@(posedge MCLK) disable iff (!RESETN) !pin_direction[3] ##1 !pin_direction[3] |-> !GPIO_OE[3] && !GPIO_OUT[3];
	endproperty
	a_input_released: assert property (p_input_released) else $error("input pin still driven");

	c_gpi_read: cover property (@(posedge MCLK) disable iff (!RESETN) REG_RD && REG_ADDR == `ADDR_GENERAL_INPUTS);
	c_status_out: cover property (@(posedge MCLK) disable iff (!RESETN) GPIO_OE[3] && GPIO_OUT[3]);
	c_pair_on: cover property (@(posedge MCLK) disable iff (!RESETN) CLKOUT_DRIVE == 4'hf);

endmodule : gpio_output_driver_ctrl_regs

// *** rtl/gpio_ctrl_defs.svh ***
// Address map, reset values and field positions of the pin and clock output control bank.
`ifndef GPIO_CTRL_DEFS_SVH
`define GPIO_CTRL_DEFS_SVH

`define ADDR_PIN_DIRECTION        16'h0030
`define ADDR_PIN_IN_FN_BIT2       16'h0031
`define ADDR_PIN_IN_FN_BIT1       16'h0032
`define ADDR_PIN_IN_FN_BIT0       16'h0033
`define ADDR_PIN_OUT_FN_BIT2      16'h0034
`define ADDR_PIN_OUT_FN_BIT1      16'h0035
`define ADDR_PIN_OUT_FN_BIT0      16'h0036
`define ADDR_PIN_OUTPUT_VALUES    16'h0038
`define ADDR_CLOCK_OUTPUT_ENABLES 16'h0039
`define ADDR_CLOCK_OUTPUT_POL     16'h003a
`define ADDR_DRIVER_STYLE_32      16'h003d
`define ADDR_DRIVER_STYLE_10      16'h003e
`define ADDR_GENERAL_INPUTS       16'h0219

`define RST_FOUR_BITS             4'h0
`define RST_IN_FN_BIT0            4'hf
`define RST_DRIVER_STYLE          8'h22
`define RST_READ_DATA             8'h00
`define RST_SYNC                  4'h0
`define ALT_IDLE_LEVEL            4'h3
`define READ_PAD                  4'h0
`define READ_UNMAPPED             8'h00

`define STYLE_HI_LSB              5
`define SE_HI_BIT                 4
`define STYLE_LO_LSB              1
`define SE_LO_BIT                 0
`define STYLE_WIDTH               3

`endif

// *** rtl/gpio_ctrl_pkg.sv ***
// Types shared by the pin and clock output control bank.
package gpio_ctrl_pkg;

	typedef enum logic [2:0] {
		IN_FN_GENERAL   = 3'h0,
		IN_FN_ALTERNATE = 3'h1
	} input_function_t;

	typedef enum logic [2:0] {
		OUT_FN_GENERAL = 3'h0,
		OUT_FN_STATUS  = 3'h1
	} output_function_t;

	typedef enum logic [2:0] {
		STYLE_HIZ    = 3'h0,
		STYLE_LVPECL = 3'h1,
		STYLE_LVDS   = 3'h2,
		STYLE_LVCMOS = 3'h3,
		STYLE_HCSL   = 3'h4
	} driver_style_t;

endpackage : gpio_ctrl_pkg

// *** rtl/clock_pair_ctrl.sv ***
// Driver control of one clock output pair: enable, style, polarity and phase of each pin.
`timescale 1ns/1ps
module clock_pair_ctrl (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          resetn,
	// Settings
	input  wire logic                          enable,
	input  wire logic                          gate,
	input  wire logic                          polarity,
	input  wire gpio_ctrl_pkg::driver_style_t  style,
	input  wire logic                          same_phase,
	// Driver control
	output      logic                          drive,
	output      gpio_ctrl_pkg::driver_style_t  style_out,
	output      logic                          q_invert,
	output      logic                          nq_invert
);
	import gpio_ctrl_pkg::*;

	logic          next_drive;
	driver_style_t next_style;
	logic          next_q_invert;
	logic          next_nq_invert;
	logic          legal;

	always_comb begin
		legal          = (style == STYLE_LVPECL) || (style == STYLE_LVDS) ||
		                 (style == STYLE_LVCMOS) || (style == STYLE_HCSL);
		next_drive     = enable && gate && legal;
		next_style     = next_drive ? style : STYLE_HIZ;
		next_q_invert  = polarity;
		// Same phase only makes sense for single-ended pins, so differential styles ignore the bit.
		next_nq_invert = (style == STYLE_LVCMOS && same_phase) ? polarity : !polarity;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive     <= 1'b0;
			style_out <= STYLE_HIZ;
			q_invert  <= 1'b0;
			nq_invert <= 1'b1;
		end else begin
			drive     <= next_drive;
			style_out <= next_style;
			q_invert  <= next_q_invert;
			nq_invert <= next_nq_invert;
		end
	end

	property p_pair_off;
		@(posedge clk) disable iff (!resetn) !enable |=> !drive && style_out == STYLE_HIZ;
	endproperty
	a_pair_off: assert property (p_pair_off) else $error("pair drives while disabled");

	property p_pair_on;
		@(posedge clk) disable iff (!resetn) enable && gate && style == STYLE_LVDS |=> drive && style_out == STYLE_LVDS;
	endproperty
	a_pair_on: assert property (p_pair_on) else $error("enabled pair not driven");

	property p_polarity;
		@(posedge clk) disable iff (!resetn) 1'b1 |=> q_invert == $past(polarity);
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity not applied");

	property p_reserved_style;
		@(posedge clk) disable iff (!resetn) style > STYLE_HCSL |=> !drive && style_out == STYLE_HIZ;
	endproperty
	a_reserved_style: assert property (p_reserved_style) else $error("reserved style drives");

	property p_same_phase;
		@(posedge clk) disable iff (!resetn) style == STYLE_LVCMOS && same_phase |=> nq_invert == q_invert;
	endproperty
	a_same_phase: assert property (p_same_phase) else $error("same phase not applied");

	property p_opposite_phase;
		@(posedge clk) disable iff (!resetn) !(style == STYLE_LVCMOS && same_phase) |=> nq_invert != q_invert;
	endproperty
	a_opposite_phase: assert property (p_opposite_phase) else $error("pins not in opposite phase");

	c_lvcmos_same: cover property (@(posedge clk) disable iff (!resetn) drive && style_out == STYLE_LVCMOS && nq_invert == q_invert);

endmodule : clock_pair_ctrl

// *** verification/board_model.sv ***
// Board model: resolves the general-purpose pin wires and supplies the PLL status levels.
`timescale 1ns/1ps
module board_model (
	// Pins
	input  wire logic [3:0] gpio_out,
	input  wire logic [3:0] gpio_oe,
	input  wire logic [3:0] level,
	output      logic [3:0] gpio_in,
	// Status
	input  wire logic [3:0] flags,
	output      logic       holdover,
	output      logic       los0,
	output      logic       los1,
	output      logic       lol
);
	// A driven pin shows the device's level, a released one the board's own level.
	assign gpio_in  = (gpio_oe & gpio_out) | (~gpio_oe & level);
	assign holdover = flags[0];
	assign los1     = flags[1];
	assign los0     = flags[2];
	assign lol      = flags[3];
endmodule : board_model

// *** verification/gpio_output_driver_ctrl_regs_test.sv ***
// Self-checking bench of the pin and clock output control bank.
`timescale 1ns/1ps
module gpio_output_driver_ctrl_regs_test;
	logic        mclk   = 0;
	logic        resetn = 0;
	logic [15:0] addr   = '0;
	logic        wr     = 0;
	logic        rd     = 0;
	logic [7:0]  wdata  = '0;
	logic [7:0]  rdata;
	logic [3:0]  gpio_in, gpio_out, gpio_oe, drive, q_inv, nq_inv;
	logic [3:0]  level  = '0;
	logic [3:0]  flags  = '0;
	logic        holdover, los0, los1, lol, ref_sel;
	logic [11:0] style;
	int          miscompares     = 0;
	int          samples_checked = 0;
	logic [15:0] reg_addr [12] = '{16'h30, 16'h31, 16'h32, 16'h33, 16'h34, 16'h35, 16'h36, 16'h38, 16'h39, 16'h3a,
		16'h3d, 16'h3e};
	logic [7:0]  reg_rst [12] = '{8'h0, 8'h0, 8'h0, 8'h0f, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h22, 8'h22};

	always #12.5 mclk = ~mclk;

	gpio_output_driver_ctrl_regs dut_u (.MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr), .REG_WR(wr),
		.REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out),
		.GPIO_OE(gpio_oe), .HOLDOVER_FLAG(holdover), .LOS_REF0(los0), .LOS_REF1(los1), .LOSS_OF_LOCK(lol),
		.MANUAL_REF_SELECT(ref_sel), .CLKOUT_DRIVE(drive), .CLKOUT_STYLE(style), .CLKOUT_Q_INVERT(q_inv),
		.CLKOUT_NQ_INVERT(nq_inv));
	board_model board_u (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .level(level), .gpio_in(gpio_in),
		.flags(flags), .holdover(holdover), .los0(los0), .los1(los1), .lol(lol));

	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Every value handed in keeps reserved bit positions zero.
	task automatic wreg(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		#2;
		addr  = a;
		wdata = d;
		wr    = 1;
		@(posedge mclk);
		#2;
		wr = 0;
	endtask : wreg

	task automatic rreg(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		#2;
		addr = a;
		rd   = 1;
		@(posedge mclk);
		#2;
		rd = 0;
		chk(rdata, e, "read data");
	endtask : rreg

	// Four edges cover the two-flop pin synchroniser plus the registered outputs.
	task automatic settle;
		repeat (4) @(posedge mclk);
		#2;
	endtask : settle

	task automatic results;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (10) @(posedge mclk);
		#2;
		resetn = 1;
		chk(nq_inv, 4'hf, "reset complement invert");
		chk(drive, 4'h0, "reset drive");
		for (int i = 0; i < 12; i++) begin
			rreg(reg_addr[i], reg_rst[i]);
		end
		rreg(16'h0037, 8'h00);
		wreg(16'h0038, 8'h05);
		wreg(16'h0030, 8'h0f);
		settle();
		chk(gpio_oe, 4'hf, "pin drive enables");
		chk(gpio_out, 4'h5, "general outputs");
		wreg(16'h0036, 8'h0f);
		for (int i = 0; i < 4; i++) begin
			flags = 4'h1 << i;
			settle();
			chk(gpio_out, flags, "status on pins");
		end
		flags = 4'hf;
		wreg(16'h0034, 8'h0f);
		settle();
		chk(gpio_out, 4'h0, "reserved output code");
		wreg(16'h0030, 8'h00);
		wreg(16'h0033, 8'h00);
		wreg(16'h0219, 8'h0f);
		level = 4'ha;
		settle();
		chk(gpio_oe, 4'h0, "released pins");
		rreg(16'h0219, 8'h0a);
		wreg(16'h0033, 8'h0c);
		level = 4'hf;
		settle();
		chk(ref_sel, 1'b1, "manual reference select");
		rreg(16'h0219, 8'h03);
		level = 4'h0;
		settle();
		chk(ref_sel, 1'b0, "manual reference low");
		wreg(16'h0033, 8'h03);
		level = 4'h3;
		wreg(16'h0039, 8'h0f);
		settle();
		chk(drive, 4'hf, "pairs enabled");
		chk(style, 12'h249, "default style");
		level = 4'h2;
		settle();
		chk(drive, 4'hc, "select bit 0 low");
		level = 4'h1;
		settle();
		chk(drive, 4'h3, "select bit 1 low");
		level = 4'h3;
		wreg(16'h003a, 8'h05);
		settle();
		chk(q_inv, 4'h5, "true pin polarity");
		chk(nq_inv, 4'ha, "complement pin polarity");
		for (int c = 0; c < 8; c++) begin
			wreg(16'h003e, {c[2:0], 1'b0, c[2:0], 1'b0});
			settle();
			chk(style[5:0], (c < 5) ? {c[2:0], c[2:0]} : 6'h00, "style code");
			chk(drive[1:0], (c > 0 && c < 5) ? 2'h3 : 2'h0, "style drive");
		end
		wreg(16'h003e, 8'h77);
		settle();
		chk(nq_inv[1:0], 2'h1, "same phase complement");
		wreg(16'h003e, 8'h66);
		settle();
		chk(nq_inv[1:0], 2'h2, "opposite phase complement");
		rreg(16'h003e, 8'h66);
		results();
	end

	// The tests need under a thousand cycles; five thousand leaves ample margin.
	initial begin
		#(25 * 5000);
		miscompares++;
		$display("Error at %0t ns: watchdog expired", $time);
		results();
	end
endmodule : gpio_output_driver_ctrl_regs_test
